// >>> rtl/ssb_spi_buffer.sv
// SPI status flags, double-buffered transmit path, receive buffer and
// Avalon-MM register slave, with a simple mode-0 shifter for either role.
// Assumes link pins arrive asynchronous to clk_sys_in; the bench resolves
// two-way pins from the output enables.
//
// Notes on behaviour
// RQ1 - Transfer completion sets receive-full flag
// RQ2 - Status read then data read clears receive-full
// RQ3 - Transmit-empty shows room in transmit buffer
// RQ4 - Status read then data write clears transmit-empty
// RQ5 - Data write without armed status read ignored
// RQ6 - Transmit-empty with enable raises interrupt request
// RQ7 - Buffer-to-shifter move sets transmit-empty
// RQ8 - Idle block loads shifter within two cycles
// RQ9 - Queued byte moves after shifter finishes
// RQ10 - Master with slave select low sets fault
// RQ11 - Fault input only when master, enabled, no output
// RQ12 - Status read then control write clears fault
// RQ13 - Data reads receive buffer, writes transmit buffer
// RQ14 - Master starts transfer when byte written
// RQ15 - Software writes data only while empty flag
// RQ16 - Software reads data before next completion
// RQ17 - Unread buffer at completion drops new byte
// RQ18 - Unused status bits read zero, ignore writes
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
module ssb_spi_buffer
  import ssb_pkg::*;
#(
  parameter int HALF_CYC = SSB_HALF_CYC
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  input  wire ssb_avm_req_t avm_req_in,
  output logic [31:0]       avm_readdata_out,
  output logic              avm_waitrequest_out,
  input  wire ssb_pin_in_t  pin_in,
  output ssb_pin_out_t      pin_out,
  output logic              tx_req_out,
  output logic              irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [3:0]  ctrl;
    logic        rf;
    logic        tef;
    logic        mode_fault_flag;
    logic        rf_arm;
    logic        tef_arm;
    logic        mode_fault_flag_arm;
    logic [7:0]  rxbuf;
    logic [7:0]  txbuf;
    logic        txfull;
    logic [7:0]  shf;
    logic [7:0]  rxsh;
    ssb_link_t   link;
    logic [2:0]  bitcnt;
    logic [7:0]  div;
    logic        sclk;
    logic [2:0]  sclk_s;
    logic [1:0]  mosi_s;
    logic [1:0]  miso_s;
    logic [1:0]  ss_s;
    logic [3:0]  evt;
    logic [3:0]  mask;
  } ssb_state_t;

  localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);

  ssb_state_t r_ff;
  ssb_state_t nxt_r;

  function automatic logic hit(input logic [SSB_AW-1:0] a, input logic [SSB_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic       req;
  logic       acc;
  logic       master_select;
  logic       fault_cond;
  logic       mode_fault_flag_set;
  logic       rise;
  logic       fall;
  logic       done;
  logic       rf_clr;
  logic       load;
  logic       dwr_ok;
  logic       ovr;
  logic [7:0] rx_byte;
  logic [7:0] status_rd;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    req   = avm_req_in.read | avm_req_in.write;
    acc   = req & r_ff.ack;
    master_select  = r_ff.ctrl[SSB_MASTER_SELECT_BIT];

    // Synchronisers: only the second stage and later are read
    nxt_r.sclk_s = {r_ff.sclk_s[1:0], pin_in.sclk};
    nxt_r.mosi_s = {r_ff.mosi_s[0], pin_in.mosi};
    nxt_r.miso_s = {r_ff.miso_s[0], pin_in.miso};
    nxt_r.ss_s   = {r_ff.ss_s[0], pin_in.ss_n};

    fault_cond = master_select & r_ff.ctrl[SSB_MFEN_BIT] & ~r_ff.ctrl[SSB_SLAVE_SELECT_OUTPUT_ENABLE_BIT]; // RQ11
    mode_fault_flag_set   = fault_cond & ~r_ff.ss_s[1]; // RQ10

    status_rd = 8'h00; // RQ18
    status_rd[SSB_RF_BIT]   = r_ff.rf;
    status_rd[SSB_TEF_BIT]  = r_ff.tef;
    status_rd[SSB_MODE_FAULT_FLAG_BIT] = r_ff.mode_fault_flag;

    // Bus slave: one wait cycle, read data captured while waiting
    nxt_r.ack = req & ~r_ff.ack;
    if (avm_req_in.read && !r_ff.ack) begin
      nxt_r.rdata = 32'h0000_0000;
      if (hit(avm_req_in.address, SSB_STATUS)) begin
        nxt_r.rdata[7:0] = status_rd;
      end else if (hit(avm_req_in.address, SSB_DATA)) begin
        nxt_r.rdata[7:0] = r_ff.rxbuf; // RQ13
      end else if (hit(avm_req_in.address, SSB_CTRL1)) begin
        nxt_r.rdata[3:0] = r_ff.ctrl;
      end else if (hit(avm_req_in.address, SSB_EVT)) begin
        nxt_r.rdata[3:0] = r_ff.evt;
      end else if (hit(avm_req_in.address, SSB_MASK)) begin
        nxt_r.rdata[3:0] = r_ff.mask;
      end
    end

    // Arming by a status read that saw the flag set
    if (acc && avm_req_in.read && hit(avm_req_in.address, SSB_STATUS)) begin
      nxt_r.rf_arm   = r_ff.rdata[SSB_RF_BIT];
      nxt_r.tef_arm  = r_ff.rdata[SSB_TEF_BIT];
      nxt_r.mode_fault_flag_arm = r_ff.rdata[SSB_MODE_FAULT_FLAG_BIT];
    end

    rf_clr = acc & avm_req_in.read & hit(avm_req_in.address, SSB_DATA) & r_ff.rf_arm; // RQ2
    if (rf_clr) begin
      nxt_r.rf     = 1'b0;
      nxt_r.rf_arm = 1'b0;
    end

    dwr_ok = acc & avm_req_in.write & hit(avm_req_in.address, SSB_DATA) & r_ff.tef_arm; // RQ5
    if (dwr_ok) begin
      nxt_r.txbuf   = avm_req_in.writedata[7:0]; // RQ13
      nxt_r.txfull  = 1'b1;
      nxt_r.tef     = 1'b0; // RQ4
      nxt_r.tef_arm = 1'b0;
    end

    if (acc && avm_req_in.write && hit(avm_req_in.address, SSB_CTRL1)) begin
      nxt_r.ctrl = avm_req_in.writedata[3:0];
      if (r_ff.mode_fault_flag_arm) begin
        nxt_r.mode_fault_flag     = 1'b0; // RQ12
        nxt_r.mode_fault_flag_arm = 1'b0;
      end
    end
    if (acc && avm_req_in.write && hit(avm_req_in.address, SSB_MASK)) begin
      nxt_r.mask = avm_req_in.writedata[3:0];
    end

    // ----------------------------------------------------------------
    // Link edges: master makes its own clock, slave follows the pin
    // ----------------------------------------------------------------
    rise = 1'b0;
    fall = 1'b0;
    if (master_select) begin
      if (r_ff.link == SSB_SHIFT) begin
        if (r_ff.div == DIV_LAST) begin
          nxt_r.div  = 8'h00;
          nxt_r.sclk = ~r_ff.sclk;
          rise       = ~r_ff.sclk;
          fall       = r_ff.sclk;
        end else begin
          nxt_r.div = r_ff.div + 8'h01;
        end
      end
    end else if (!r_ff.ss_s[1]) begin
      rise = r_ff.sclk_s[1] & ~r_ff.sclk_s[2];
      fall = ~r_ff.sclk_s[1] & r_ff.sclk_s[2];
    end

    rx_byte = r_ff.rxsh;
    done    = 1'b0;
    if (rise) begin
      nxt_r.rxsh = {r_ff.rxsh[6:0], master_select ? r_ff.miso_s[1] : r_ff.mosi_s[1]};
      rx_byte    = nxt_r.rxsh;
    end
    if (fall) begin
      if (r_ff.bitcnt == SSB_LAST_BIT) begin
        done         = 1'b1;
        nxt_r.bitcnt = 3'h0;
        nxt_r.link   = SSB_IDLE;
      end else begin
        nxt_r.bitcnt = r_ff.bitcnt + 3'h1;
        nxt_r.shf    = {r_ff.shf[6:0], 1'b0};
      end
    end
    // A slave deselected mid-byte starts the next byte afresh
    if (!master_select && r_ff.ss_s[1]) begin
      nxt_r.bitcnt = 3'h0;
    end

    // Completion: set beats a clear in the same cycle
    ovr = 1'b0;
    if (done) begin
      if (r_ff.rf && !rf_clr) begin
        ovr = 1'b1; // RQ17
      end else begin
        nxt_r.rxbuf = r_ff.rxsh;
        nxt_r.rf    = 1'b1; // RQ1
      end
    end

    // Buffer to shifter once the shifter is free; a slave only swaps
    // between bytes so the peer never sees a half-changed shifter
    load = r_ff.txfull & (r_ff.link == SSB_IDLE) & ~done
           & (master_select ? ~r_ff.mode_fault_flag : (r_ff.ss_s[1] | r_ff.bitcnt == 3'h0)); // RQ8 RQ9
    if (load) begin
      nxt_r.shf    = r_ff.txbuf;
      nxt_r.txfull = 1'b0;
      nxt_r.tef    = 1'b1; // RQ7
      nxt_r.link   = SSB_SHIFT; // RQ14
      nxt_r.div    = 8'h00;
      nxt_r.sclk   = 1'b0;
    end

    // A second master steals the link: abort and drop back to slave
    if (mode_fault_flag_set) begin
      nxt_r.mode_fault_flag                 = 1'b1;
      nxt_r.ctrl[SSB_MASTER_SELECT_BIT]   = 1'b0;
      nxt_r.link                 = SSB_IDLE;
      nxt_r.bitcnt               = 3'h0;
      nxt_r.sclk                 = 1'b0;
    end

    // Sticky events, write one to clear, set wins
    nxt_r.evt = r_ff.evt;
    if (acc && avm_req_in.write && hit(avm_req_in.address, SSB_EVT)) begin
      nxt_r.evt = r_ff.evt & ~avm_req_in.writedata[3:0];
    end
    nxt_r.evt[SSB_EV_RX]   = nxt_r.evt[SSB_EV_RX] | (done & ~ovr);
    nxt_r.evt[SSB_EV_TX]   = nxt_r.evt[SSB_EV_TX] | load;
    nxt_r.evt[SSB_EV_MODE_FAULT_FLAG] = nxt_r.evt[SSB_EV_MODE_FAULT_FLAG] | (mode_fault_flag_set & ~r_ff.mode_fault_flag);
    nxt_r.evt[SSB_EV_OVR]  = nxt_r.evt[SSB_EV_OVR] | ovr;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r_ff        <= '0;
      r_ff.tef    <= 1'b1; // RQ3
      r_ff.link   <= SSB_IDLE;
      r_ff.ctrl   <= SSB_CTRL_RST;
      r_ff.rxbuf  <= SSB_DATA_RST;
      r_ff.txbuf  <= SSB_DATA_RST;
      r_ff.sclk_s <= 3'h0;
      r_ff.ss_s   <= 2'h3;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avm_waitrequest_out = req & ~r_ff.ack;
  assign avm_readdata_out    = r_ff.rdata;
  assign tx_req_out          = r_ff.tef & r_ff.ctrl[SSB_TIE_BIT]; // RQ6
  assign irq_out             = |(r_ff.evt & r_ff.mask);

  always_comb begin
    pin_out.sclk    = r_ff.sclk;
    pin_out.sclk_oe = master_select;
    pin_out.mosi    = r_ff.shf[7];
    pin_out.mosi_oe = master_select;
    pin_out.miso    = r_ff.shf[7];
    pin_out.miso_oe = ~master_select & ~r_ff.ss_s[1];
    pin_out.ss_n    = r_ff.link != SSB_SHIFT;
    pin_out.ss_n_oe = master_select & r_ff.ctrl[SSB_SLAVE_SELECT_OUTPUT_ENABLE_BIT] & r_ff.ctrl[SSB_MFEN_BIT];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_rf_sets: assert property (done && !r_ff.rf |=> r_ff.rf && r_ff.rxbuf == $past(r_ff.rxsh)) // RQ1
    else $error("receive-full not set on completion");

  a_rf_clears: assert property (rf_clr && !done |=> !r_ff.rf) // RQ2
    else $error("receive-full not cleared after armed data read");

  a_tef_room: assert property (r_ff.tef == !r_ff.txfull) // RQ3
    else $error("transmit-empty disagrees with buffer state");

  a_wr_ignored: assert property (acc && avm_req_in.write && hit(avm_req_in.address, SSB_DATA)
                                 && !r_ff.tef_arm && !r_ff.txfull |=> !r_ff.txfull) // RQ5
    else $error("unarmed data write was accepted");

  a_idle_load: assert property (dwr_ok && r_ff.link == SSB_IDLE && master_select && !r_ff.mode_fault_flag
                                |-> ##[1:2] r_ff.tef && r_ff.link == SSB_SHIFT) // RQ8
    else $error("idle master did not load shifter in two cycles");

  a_tx_request: assert property ($rose(r_ff.tef) && r_ff.ctrl[SSB_TIE_BIT] |-> tx_req_out) // RQ6
    else $error("transmit request missing");

  a_mode_fault_flag_sets: assert property (fault_cond && !r_ff.ss_s[1] |=> r_ff.mode_fault_flag) // RQ10
    else $error("mode fault not flagged");

  a_mode_fault_flag_never: assert property (!fault_cond && !r_ff.mode_fault_flag |=> !r_ff.mode_fault_flag) // RQ11
    else $error("mode fault set outside fault configuration");

  a_ovr_keeps: assert property (done && r_ff.rf && !rf_clr |=> $stable(r_ff.rxbuf) && r_ff.rf) // RQ17
    else $error("overrun overwrote receive buffer");

  a_bus_answer: assert property (req && !r_ff.ack |=> !avm_waitrequest_out || !req)
    else $error("bus answer later than one wait cycle");

  a_tef_reload: assert property (load && !mode_fault_flag_set |=> r_ff.tef && r_ff.link == SSB_SHIFT) // RQ7
    else $error("shifter load did not set transmit-empty");

  a_queue_moves: assert property (done && r_ff.txfull && master_select && !r_ff.mode_fault_flag && !mode_fault_flag_set // RQ9
                                  |=> r_ff.link == SSB_IDLE
                                  ##1 r_ff.tef && r_ff.link == SSB_SHIFT)
    else $error("queued byte did not follow finished transfer");

  a_mode_fault_flag_clears: assert property (r_ff.mode_fault_flag_arm && !mode_fault_flag_set && acc && avm_req_in.write // RQ12
                                  && hit(avm_req_in.address, SSB_CTRL1) |=> !r_ff.mode_fault_flag)
    else $error("mode fault not cleared by armed control write");

  a_status_zero: assert property (avm_req_in.read && r_ff.ack // RQ18
                                  && hit(avm_req_in.address, SSB_STATUS)
                                  |-> (avm_readdata_out & 32'hffff_ff4f) == 32'h0000_0000)
    else $error("unused status bits not zero");

  a_data_reads: assert property (avm_req_in.read && r_ff.ack // RQ13
                                 && hit(avm_req_in.address, SSB_DATA)
                                 |-> avm_readdata_out == {24'h00_0000, $past(r_ff.rxbuf)})
    else $error("data read did not return receive buffer");

endmodule : ssb_spi_buffer

// >>> rtl/ssb_pkg.sv
// Constants, register map and carrier types of the SPI status and data buffer.
// Assumes a single 40 MHz system clock; every link pin is asynchronous to it.
package ssb_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SSB_SYS_PERIOD_NS  = 25;
  localparam int SSB_SCLK_PERIOD_NS = 200;
  localparam int SSB_HALF_CYC       = SSB_SCLK_PERIOD_NS / (2 * SSB_SYS_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         SSB_AW       = 5;
  localparam logic [4:0] SSB_STATUS   = 5'h00;
  localparam logic [4:0] SSB_DATA     = 5'h04;
  localparam logic [4:0] SSB_CTRL1    = 5'h08;
  localparam logic [4:0] SSB_EVT      = 5'h0c;
  localparam logic [4:0] SSB_MASK     = 5'h10;

  // Status bits
  localparam int SSB_RF_BIT   = 7;
  localparam int SSB_TEF_BIT  = 5;
  localparam int SSB_MODE_FAULT_FLAG_BIT = 4;

  // Control register one bits
  localparam int SSB_MASTER_SELECT_BIT = 0;
  localparam int SSB_SLAVE_SELECT_OUTPUT_ENABLE_BIT = 1;
  localparam int SSB_MFEN_BIT = 2;
  localparam int SSB_TIE_BIT  = 3;

  // Event bits (sticky status and mask share this layout)
  localparam int SSB_EV_RX   = 0;
  localparam int SSB_EV_TX   = 1;
  localparam int SSB_EV_MODE_FAULT_FLAG = 2;
  localparam int SSB_EV_OVR  = 3;

  localparam logic [7:0] SSB_DATA_RST = 8'h00;
  localparam logic [3:0] SSB_CTRL_RST = 4'h0;
  localparam logic [2:0] SSB_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic {SSB_IDLE, SSB_SHIFT} ssb_link_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [SSB_AW-1:0] address;
    logic [31:0]       writedata;
  } ssb_avm_req_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } ssb_pin_in_t;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss_n;
    logic ss_n_oe;
  } ssb_pin_out_t;
endpackage : ssb_pkg

// >>> test/ssb_peer.sv
// Behavioural SPI slave that sits on the far side of the buffer: mode 0, MSB first.
// Assumes the serial clock idles low and slave select frames one or more bytes.
`timescale 1ns/1ps
module ssb_peer (
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       ss_n_in,
  input  wire logic [7:0] seed_in,
  output logic            miso_out,
  output logic [7:0]      rx_out,
  output int              count_out
);
  logic [7:0] sh_ff   = 8'h00;
  logic [7:0] in_ff   = 8'h00;
  logic [7:0] rx_ff   = 8'h00;
  int         cnt_ff  = 0;
  int         bit_ff  = 0;
  logic       last_ff = 1'b0;
  logic       sel_ff  = 1'b0;
  logic       sclk_ff = 1'b0;
  assign rx_out    = rx_ff;
  assign count_out = cnt_ff;
  // Deselected line shows the inverse of the last bit so a stale value never matches
  assign miso_out = ss_n_in ? ~last_ff : sh_ff[7];
  // One process owns all state; byte n carries seed plus n, so each byte is distinct
  always @(ss_n_in or sclk_in) begin
    if (ss_n_in) begin
      sel_ff = 1'b0;
    end else if (!sel_ff) begin
      sel_ff = 1'b1;
      sh_ff  = seed_in + cnt_ff[7:0];
      bit_ff = 0;
    end else if (sclk_in && !sclk_ff) begin
      in_ff   = {in_ff[6:0], mosi_in};
      last_ff = sh_ff[7];
      bit_ff++;
      if (bit_ff == 8) begin
        rx_ff = in_ff;
        cnt_ff++;
      end
    end else if (!sclk_in && sclk_ff) begin
      if (bit_ff == 8) begin
        sh_ff  = seed_in + cnt_ff[7:0];
        bit_ff = 0;
      end else begin
        sh_ff = sh_ff << 1;
      end
    end
    sclk_ff = sclk_in;
  end
endmodule : ssb_peer

// >>> test/ssb_spi_buffer_tb.sv
// Self-checking bench for the SPI status and data buffer, master role.
// Assumes the peer model as the link partner and a 40 MHz system clock.
`timescale 1ns/1ps
module ssb_spi_buffer_tb;
  import ssb_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         rst_in     = 1'b1;
  ssb_avm_req_t req        = '0;
  logic [31:0]  rdata_w;
  logic [31:0]  rd_val;
  logic         wreq;
  logic         tx_req;
  logic         irq;
  logic         miso_p;
  logic         tb_ss_n    = 1'b1;
  ssb_pin_out_t po;
  ssb_pin_in_t  pi;
  logic [7:0]   seed       = 8'h00;
  logic [7:0]   rxp;
  logic [7:0]   a;
  logic [7:0]   b;
  int           cnt;
  int           nb;
  int           failures   = 0;
  int           check_count = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;
  assign pi.sclk = po.sclk_oe ? po.sclk : 1'b0;
  assign pi.mosi = po.mosi_oe ? po.mosi : 1'b0;
  assign pi.ss_n = po.ss_n_oe ? po.ss_n : tb_ss_n;
  assign pi.miso = po.miso_oe ? po.miso : miso_p;

  ssb_spi_buffer #(.HALF_CYC(4)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .avm_req_in(req), .avm_readdata_out(rdata_w), .avm_waitrequest_out(wreq),
    .pin_in(pi), .pin_out(po), .tx_req_out(tx_req), .irq_out(irq));
  ssb_peer peer_u (.sclk_in(pi.sclk), .mosi_in(pi.mosi), .ss_n_in(pi.ss_n),
    .seed_in(seed), .miso_out(miso_p), .rx_out(rxp), .count_out(cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] peer_byte(input logic [7:0] s, input int n);
    return {24'h0, 8'(s + n[7:0])};
  endfunction : peer_byte

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held to the rising edge at which waitrequest is sampled low; data taken there.
  // Just after an edge the design's registers still show the values that stood before it.
  task automatic bus(input logic rd, input logic [4:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    req <= '{read: rd, write: ~rd, address: ad, writedata: wd};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rd_val = rdata_w;
    req <= '0;
    if (n >= 50) chk(32'h0, 32'h1, "bus timeout");
  endtask : bus

  task automatic rdchk(input logic [4:0] ad, input logic [31:0] exp, input string what);
    bus(1'b1, ad, 32'h0);
    chk(rd_val, exp, what);
  endtask : rdchk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7b34));
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bus(1'b0, SSB_CTRL1, 32'hf);
    bus(1'b0, SSB_DATA, 32'h5a);
    repeat (100) @(posedge clk_sys_in);
    chk(32'(cnt), 32'h0, "unarmed write sent");
    rdchk(SSB_STATUS, 32'h20, "status reset");
    rdchk(SSB_DATA, 32'h0, "data reset");
    rdchk(5'h14, 32'h0, "unmapped read");
    chk({31'h0, tx_req}, 32'h1, "tx request");
    bus(1'b0, SSB_MASK, 32'hf);
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      b = (i == 0) ? 8'hff : 8'($urandom);
      seed = (i == 1) ? 8'h00 : 8'($urandom);
      nb = cnt;
      bus(1'b1, SSB_STATUS, 32'h0);
      bus(1'b0, SSB_DATA, {24'h0, a});
      rdchk(SSB_STATUS, 32'h20, "empty after load");
      bus(1'b0, SSB_DATA, {24'h0, b});
      rdchk(SSB_STATUS, 32'h0, "empty while queued");
      chk({31'h0, tx_req}, 32'h0, "tx request queued");
      for (int n = 0; n < 400 && cnt < nb + 1; n++) @(posedge clk_sys_in);
      chk({24'h0, rxp}, {24'h0, a}, "peer got first byte");
      for (int n = 0; n < 400 && cnt < nb + 2; n++) @(posedge clk_sys_in);
      repeat (4) @(posedge clk_sys_in);
      chk(32'(cnt), 32'(nb + 2), "peer byte count");
      rdchk(SSB_STATUS, 32'ha0, "full and empty");
      chk({31'h0, irq}, 32'h1, "irq events");
      rdchk(SSB_EVT, 32'hb, "rx tx overrun events");
      rdchk(SSB_DATA, peer_byte(seed, nb), "kept byte");
      rdchk(SSB_STATUS, 32'h20, "full cleared");
      chk({24'h0, rxp}, {24'h0, b}, "peer got byte");
      bus(1'b0, SSB_EVT, 32'hf);
      @(posedge clk_sys_in);
      chk({31'h0, irq}, 32'h0, "irq cleared");
    end
    // Fault only counts as master with fault enable and select output off
    bus(1'b0, SSB_CTRL1, 32'h4);
    tb_ss_n <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    rdchk(SSB_STATUS, 32'h20, "no fault as slave");
    tb_ss_n <= 1'b1;
    bus(1'b0, SSB_MASK, 32'h0);
    bus(1'b0, SSB_CTRL1, 32'hd);
    tb_ss_n <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    rdchk(SSB_STATUS, 32'h30, "fault set");
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b0, SSB_MASK, 32'h4);
    @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    tb_ss_n <= 1'b1;
    bus(1'b0, SSB_CTRL1, 32'hd);
    rdchk(SSB_STATUS, 32'h20, "fault cleared");
    end_sim();
  end

  initial begin
    #500000;
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
endmodule : ssb_spi_buffer_tb
